// ### design/rsc_params.svh
// Holds the register offsets, field positions, reset values and timing counts of the run/stop control block.
// Assumes it is included by bare name by every file that needs these figures.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses on the APB).
// ****************************************************************
`define RSC_OFF_CTRL    8'h00
`define RSC_OFF_STAT    8'h04
`define RSC_OFF_RETAIN  8'h08
`define RSC_OFF_INPUT   8'h0C
`define RSC_OFF_PROG    8'h10

// ****************************************************************
// Field positions.
// ****************************************************************
`define RSC_CTRL_RUN    0
`define RSC_CTRL_STOP   1
`define RSC_CTRL_BEGIN  2
`define RSC_CTRL_COMMIT 3
`define RSC_STAT_RUN    0
`define RSC_STAT_EMPTY  1
`define RSC_STAT_EXP    2
`define RSC_STAT_LINK   3
`define RSC_STAT_SPD100 4
`define RSC_STAT_NODISP 5
`define RSC_STAT_ENTRY  6

// ****************************************************************
// Reset values.
// ****************************************************************
`define RSC_RETAIN_RST  8'h00

// ****************************************************************
// Timing.
// ****************************************************************
`define RSC_CLK_MHZ     50
`define RSC_SCAN_US     100
`define RSC_SCAN_CYC    (`RSC_SCAN_US * `RSC_CLK_MHZ)
`define RSC_BLINK_MS    250
`define RSC_BLINK_CYC   (`RSC_BLINK_MS * 1000 * `RSC_CLK_MHZ)
// Boot outlasts the pin synchroniser, so straps and module detection are settled at the decision.
`define RSC_BOOT_CYC    5

`endif

// ### design/rsc_pkg.sv
// Holds the types shared by the run/stop control block and its bus.
// Assumes an APB master with 8-bit addresses and 32-bit data.
package rsc_pkg;

   typedef enum logic [2:0] {
      RSC_BOOT,
      RSC_COPY,
      RSC_STOP,
      RSC_RUN,
      RSC_ENTRY
   } rsc_mode_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rsc_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } rsc_apb_rsp_s;

endpackage

// ### design/rsc_sync.sv
// Holds the three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; the output moves only when stages two and three agree.
`timescale 1ns/10ps
module rsc_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rsc_sync_s;

   rsc_sync_s s_ff;
   rsc_sync_s nxt_s;

   always_comb begin
      nxt_s    = s_ff;
      nxt_s.s1 = d;
      nxt_s.s2 = s_ff.s1;
      nxt_s.s3 = s_ff.s2;
      nxt_s.q  = (s_ff.s2 & s_ff.s3) | (s_ff.q & (s_ff.s2 ^ s_ff.s3));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   assign q = s_ff.q;
endmodule

// ### design/rsc_ctrl.sv
// Holds the start-up and run/stop control of the base unit with its APB register file.
// Assumes APB, card, backup-store and retention signals come from logic on pclk; the remaining pins are asynchronous.
`timescale 1ns/10ps
`include "rsc_params.svh"

// Overview of operation
// - In stop, the input image is never refreshed from the pins.
// - In stop, the stored program is not evaluated.
// - In stop, every output is held off.
// - In run, the inputs are sampled once per scan cycle.
// - In run, outputs follow the stored program evaluated on the input image.
// - Without any program at power-on, stay stopped and flag the empty program.
// - A card program at power-on is copied over the internal one.
// - With a program present, resume the run or stop state held before power loss.
// - A unit without display goes to run at power-on when a program is present; LED turns green.
// - Any retentive function makes the unit keep its values over power loss.
// - Power loss during program entry leaves no program afterwards.
// - The network LED flashes orange during traffic.
// - The network LED is steady green with link and no traffic.
// - The network port runs at ten or one hundred megabits.
module rsc_ctrl
   import rsc_pkg::*;
#(
   parameter int          NIN       = 8,
   parameter int          NOUT      = 4,
   parameter int unsigned SCAN_CYC  = `RSC_SCAN_CYC,
   parameter int unsigned BLINK_CYC = `RSC_BLINK_CYC
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        ce,
   input  wire rsc_pkg::rsc_apb_req_s       apb_req,
   output rsc_pkg::rsc_apb_rsp_s            apb_rsp,
   input  wire logic [NIN-1:0]              in_pins,
   output logic      [NOUT-1:0]             q_o,
   input  wire logic                        nodisp_strap,
   input  wire logic                        exp_present,
   input  wire logic                        eth_link,
   input  wire logic                        eth_activity,
   input  wire logic                        eth_speed100,
   input  wire logic                        card_has_prog,
   input  wire logic [NIN-1:0]              card_data,
   output logic                             card_rd_o,
   output logic      [$clog2(NOUT+1)-1:0]   card_addr_o,
   input  wire logic                        nv_prog_valid,
   input  wire logic                        nv_run,
   input  wire logic                        perm_retentive,
   output logic                             nv_prog_valid_o,
   output logic                             nv_run_o,
   output logic                             nv_keep_o,
   output logic                             prog_empty_o,
   output logic                             led_green_o,
   output logic                             led_red_o,
   output logic                             eth_green_o,
   output logic                             eth_orange_o
);
   import rsc_pkg::*;

   localparam int IW = $clog2(NOUT+1);
   localparam int SW = NIN + 5;

   typedef struct packed {
      rsc_mode_e                 mode;
      logic [NOUT-1:0][NIN-1:0]  prog;
      logic [IW-1:0]             idx;
      logic [2:0]                boot_cnt;
      logic                      prog_valid;
      logic                      keep;
      logic                      nodisp;
      logic                      exp_seen;
      logic [7:0]                retain;
      logic [NIN-1:0]            in_img;
      logic [NOUT-1:0]           q;
      logic [31:0]               scan_cnt;
      logic [31:0]               blink_cnt;
      logic                      blink;
      logic                      act_hold;
      logic                      led_green;
      logic                      led_red;
      logic                      eth_green;
      logic                      eth_orange;
      logic                      card_rd;
      logic                      prog_empty;
      rsc_apb_rsp_s              rsp;
   } rsc_state_s;

   rsc_state_s     s_ff;
   rsc_state_s     nxt_s;
   logic [SW-1:0]  sync_q;
   logic [NIN-1:0] in_sync;
   logic           link_s;
   logic           act_s;
   logic           spd_s;
   logic           nodisp_s;
   logic           exp_s;
   logic [NOUT-1:0] eval_w;
   logic           tick;
   logic           setup;
   logic           acc;
   logic [7:0]     poff;
   logic           prog_hit;
   logic           hit;
   logic [31:0]    rdata;

   // ****************************************************************
   // Pin synchronisation.
   // ****************************************************************
   rsc_sync #(.W(SW)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       ({in_pins, eth_link, eth_activity, eth_speed100, nodisp_strap, exp_present}),
      .q       (sync_q)
   );

   assign {in_sync, link_s, act_s, spd_s, nodisp_s, exp_s} = sync_q;

   // ****************************************************************
   // Program evaluation: an output is the AND of the inputs its entry selects, off for an empty entry.
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NOUT; gi++) begin : g_eval
         assign eval_w[gi] = (|s_ff.prog[gi]) & (&(s_ff.in_img | ~s_ff.prog[gi]));
      end
   endgenerate

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   always_comb begin
      nxt_s     = s_ff;
      tick      = 1'b0;
      setup     = apb_req.psel & ~apb_req.penable;
      acc       = apb_req.psel & apb_req.penable & s_ff.rsp.pready;
      poff      = apb_req.paddr - `RSC_OFF_PROG;
      prog_hit  = (apb_req.paddr >= `RSC_OFF_PROG) && (poff[1:0] == 2'b00) && (32'(poff[7:2]) < 32'(NOUT));
      hit       = prog_hit || apb_req.paddr == `RSC_OFF_CTRL || apb_req.paddr == `RSC_OFF_STAT ||
                  apb_req.paddr == `RSC_OFF_RETAIN || apb_req.paddr == `RSC_OFF_INPUT;
      rdata     = 32'h0000_0000;
      nxt_s.rsp.pready = 1'b0;

      if (s_ff.scan_cnt == SCAN_CYC - 1) begin
         nxt_s.scan_cnt = 32'h0000_0000;
         tick           = 1'b1;
      end else begin
         nxt_s.scan_cnt = s_ff.scan_cnt + 32'h0000_0001;
      end

      if (s_ff.blink_cnt == BLINK_CYC - 1) begin
         nxt_s.blink_cnt = 32'h0000_0000;
         nxt_s.blink     = ~s_ff.blink;
         nxt_s.act_hold  = act_s;
      end else begin
         nxt_s.blink_cnt = s_ff.blink_cnt + 32'h0000_0001;
         nxt_s.act_hold  = s_ff.act_hold | act_s;
      end

      unique case (s_ff.mode)
         RSC_BOOT: begin
            nxt_s.boot_cnt = s_ff.boot_cnt + 3'h1;
            if (s_ff.boot_cnt == 3'(`RSC_BOOT_CYC - 1)) begin
               nxt_s.nodisp   = nodisp_s;
               nxt_s.exp_seen = exp_s;
               if (card_has_prog) begin
                  nxt_s.mode = RSC_COPY;
                  nxt_s.idx  = '0;
               end else if (nv_prog_valid) begin
                  nxt_s.prog_valid = 1'b1;
                  nxt_s.mode       = (nv_run || nodisp_s) ? RSC_RUN : RSC_STOP;
               end else begin
                  nxt_s.prog_valid = 1'b0;
                  nxt_s.mode       = RSC_STOP;
               end
            end
         end
         RSC_COPY: begin
            nxt_s.prog[s_ff.idx[$clog2(NOUT)-1:0]] = card_data;
            nxt_s.idx = s_ff.idx + IW'(1);
            if (32'(s_ff.idx) == NOUT - 1) begin
               nxt_s.prog_valid = 1'b1;
               nxt_s.mode       = (nv_run || s_ff.nodisp) ? RSC_RUN : RSC_STOP;
            end
         end
         RSC_RUN: begin
            if (tick) begin
               nxt_s.in_img = in_sync;
               nxt_s.q      = eval_w;
            end
         end
         RSC_STOP, RSC_ENTRY: begin
         end
      endcase

      if (setup) begin
         if (apb_req.paddr == `RSC_OFF_STAT) begin
            rdata[`RSC_STAT_RUN]    = s_ff.mode == RSC_RUN;
            rdata[`RSC_STAT_EMPTY]  = ~s_ff.prog_valid;
            rdata[`RSC_STAT_EXP]    = s_ff.exp_seen;
            rdata[`RSC_STAT_LINK]   = link_s;
            rdata[`RSC_STAT_SPD100] = spd_s;
            rdata[`RSC_STAT_NODISP] = s_ff.nodisp;
            rdata[`RSC_STAT_ENTRY]  = s_ff.mode == RSC_ENTRY;
         end else if (apb_req.paddr == `RSC_OFF_RETAIN) begin
            rdata[7:0] = s_ff.retain;
         end else if (apb_req.paddr == `RSC_OFF_INPUT) begin
            rdata[NIN-1:0] = s_ff.in_img;
         end else if (prog_hit) begin
            rdata[NIN-1:0] = s_ff.prog[poff[$clog2(NOUT)+1:2]];
         end
         nxt_s.rsp.prdata  = rdata;
         nxt_s.rsp.pready  = 1'b1;
         nxt_s.rsp.pslverr = ~hit;
      end

      if (acc && apb_req.pwrite && !s_ff.rsp.pslverr) begin
         if (apb_req.paddr == `RSC_OFF_CTRL) begin
            if (apb_req.pwdata[`RSC_CTRL_STOP] && s_ff.mode == RSC_RUN) begin
               nxt_s.mode = RSC_STOP;
            end else if (apb_req.pwdata[`RSC_CTRL_RUN] && s_ff.mode == RSC_STOP && s_ff.prog_valid) begin
               nxt_s.mode = RSC_RUN;
            end else if (apb_req.pwdata[`RSC_CTRL_BEGIN] && s_ff.mode == RSC_STOP) begin
               nxt_s.mode       = RSC_ENTRY;
               nxt_s.prog_valid = 1'b0;
            end else if (apb_req.pwdata[`RSC_CTRL_COMMIT] && s_ff.mode == RSC_ENTRY) begin
               nxt_s.mode       = RSC_STOP;
               nxt_s.prog_valid = 1'b1;
            end
         end else if (apb_req.paddr == `RSC_OFF_RETAIN) begin
            nxt_s.retain = apb_req.pwdata[7:0];
         end else if (prog_hit && s_ff.mode == RSC_ENTRY) begin
            nxt_s.prog[poff[$clog2(NOUT)+1:2]] = apb_req.pwdata[NIN-1:0];
         end
      end

      // Leaving run clears the outputs in the same edge, so no output lingers.
      if (nxt_s.mode != RSC_RUN) begin
         nxt_s.q = '0;
      end

      nxt_s.keep       = (|s_ff.retain) | perm_retentive;
      nxt_s.led_green  = nxt_s.mode == RSC_RUN;
      nxt_s.led_red    = nxt_s.mode != RSC_RUN;
      nxt_s.eth_orange = link_s & nxt_s.act_hold & s_ff.blink;
      nxt_s.eth_green  = link_s & ~nxt_s.act_hold;
      nxt_s.card_rd    = nxt_s.mode == RSC_COPY;
      nxt_s.prog_empty = ~nxt_s.prog_valid & (nxt_s.mode != RSC_BOOT) & (nxt_s.mode != RSC_COPY);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff           <= '0;
         s_ff.mode      <= RSC_BOOT;
         s_ff.retain    <= `RSC_RETAIN_RST;
         s_ff.led_red   <= 1'b1;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign apb_rsp         = s_ff.rsp;
   assign q_o             = s_ff.q;
   assign card_rd_o       = s_ff.card_rd;
   assign card_addr_o     = s_ff.idx;
   assign nv_prog_valid_o = s_ff.prog_valid;
   assign nv_run_o        = s_ff.led_green;
   assign nv_keep_o       = s_ff.keep;
   assign prog_empty_o    = s_ff.prog_empty;
   assign led_green_o     = s_ff.led_green;
   assign led_red_o       = s_ff.led_red;
   assign eth_green_o     = s_ff.eth_green;
   assign eth_orange_o    = s_ff.eth_orange;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   no_sample_stop_a: assert property (ce && s_ff.mode == RSC_STOP |=> $stable(s_ff.in_img))
      else $error("Input image changed while stopped.");
   no_eval_stop_a: assert property (ce && s_ff.mode == RSC_STOP && s_ff.q == '0 ##1 s_ff.mode == RSC_STOP
      |-> s_ff.q == '0)
      else $error("Program evaluated while stopped.");
   outputs_off_a: assert property (s_ff.mode != RSC_RUN |-> q_o == '0)
      else $error("Output on while not running.");
   sample_run_a: assert property (ce && tick && s_ff.mode == RSC_RUN |=> s_ff.in_img == $past(in_sync))
      else $error("Inputs not sampled on scan tick.");
   eval_run_a: assert property (ce && tick && s_ff.mode == RSC_RUN ##1 s_ff.mode == RSC_RUN
      |-> q_o == $past(eval_w))
      else $error("Outputs do not follow program.");
   empty_stop_a: assert property (prog_empty_o |-> s_ff.mode != RSC_RUN && !nv_prog_valid_o)
      else $error("Empty program yet running.");
   card_copy_a: assert property (ce && s_ff.mode == RSC_COPY |=> s_ff.prog[$past(s_ff.idx)] == $past(card_data))
      else $error("Card word not copied.");
   resume_a: assert property (ce && s_ff.mode == RSC_BOOT && nv_prog_valid && !card_has_prog && nv_run
      && s_ff.boot_cnt == 3'(`RSC_BOOT_CYC - 1) |=> s_ff.mode == RSC_RUN ##1 led_green_o)
      else $error("Run state not restored.");
   nodisp_run_a: assert property ($past(s_ff.mode) == RSC_COPY && s_ff.mode == RSC_STOP |-> !s_ff.nodisp)
      else $error("Unit without display stayed stopped.");
   keep_a: assert property (ce && perm_retentive |=> nv_keep_o)
      else $error("Retention not kept.");
   entry_invalid_a: assert property (s_ff.mode == RSC_ENTRY |-> !nv_prog_valid_o)
      else $error("Program valid during entry.");
   eth_steady_a: assert property (ce && link_s && !s_ff.act_hold && !act_s |=> eth_green_o && !eth_orange_o)
      else $error("Network LED not steady green.");

   boot_run_c: cover property (s_ff.mode == RSC_BOOT ##[1:8] s_ff.mode == RSC_RUN);
   copy_done_c: cover property (s_ff.mode == RSC_COPY ##[1:64] s_ff.mode == RSC_STOP);
   entry_commit_c: cover property (s_ff.mode == RSC_ENTRY ##[1:200] s_ff.mode == RSC_STOP);
   orange_c: cover property (eth_orange_o);
endmodule

// ### tb/rsc_store_model.sv
// Holds a model of the removable program card and of the backup store behind the run/stop control.
// Assumes the same clock as the control block; the store keeps its contents while reset is low.
`timescale 1ns/10ps
module rsc_store_model #(
   parameter int NIN    = 8,
   parameter int NOUT   = 4,
   parameter int SETTLE = 15
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      card_in,
   input  wire logic                      card_rd,
   input  wire logic [$clog2(NOUT+1)-1:0] card_addr,
   input  wire logic                      nv_prog_valid_o,
   input  wire logic                      nv_run_o,
   input  wire logic                      exp_power,
   output logic                           card_has_prog,
   output logic      [NIN-1:0]            card_data,
   output logic                           nv_prog_valid,
   output logic                           nv_run,
   output logic                           exp_present,
   output logic                           exp_green,
   output logic                           exp_red
);
   // ****************************************************************
   // Card and backup store.
   // ****************************************************************
   logic [NIN-1:0] word;
   logic [4:0]     up;
   initial begin
      nv_prog_valid = 1'b0;
      nv_run        = 1'b0;
   end
   assign word          = NIN'(8'h03) << (2 * card_addr);
   assign card_has_prog = card_in;
   // The expansion module talks to its left neighbour while powered and the base is out of reset.
   assign exp_present   = exp_power;
   assign exp_green     = exp_power & presetn;
   assign exp_red       = ~exp_green;
   // An idle card read shows the inverse word, so a stray read is visible.
   assign card_data     = card_rd ? word : ~word;
   // The store only takes new values once start-up has settled.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up <= 5'h00;
      end else if (up != 5'(SETTLE)) begin
         up <= up + 5'h01;
      end else begin
         nv_prog_valid <= nv_prog_valid_o;
         nv_run        <= nv_run_o;
      end
   end
endmodule

// ### tb/run_stop_startup_control_tb.sv
// Holds the self-checking testbench of the run/stop start-up control.
// Assumes rsc_ctrl, its package and the store model are compiled first.
`timescale 1ns/10ps
`include "rsc_params.svh"
module run_stop_startup_control_tb;
   import rsc_pkg::*;
   localparam int NIN  = 8;
   localparam int NOUT = 4;
   localparam int AW   = $clog2(NOUT+1);
   logic              pclk, presetn, ce, nodisp, exp_present, exp_pwr, eth_link, eth_act, eth_spd, card_in, card_has;
   logic              card_rd, nvp, nvr, perm, nvp_o, nvr_o, keep, empty, lg, lr, eg, eo, err, exp_g, exp_r;
   rsc_apb_req_s      req;
   rsc_apb_rsp_s      rsp;
   logic [NIN-1:0]    in_pins, card_data;
   logic [NOUT-1:0]   q_o;
   logic [AW-1:0]     card_addr;
   logic [31:0]       rd;
   int                errors, compares, on;

   always #10 pclk = ~pclk;

   rsc_ctrl #(.NIN(NIN), .NOUT(NOUT), .SCAN_CYC(8), .BLINK_CYC(4)) u_dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .apb_rsp(rsp), .in_pins(in_pins), .q_o(q_o),
      .nodisp_strap(nodisp), .exp_present(exp_present), .eth_link(eth_link), .eth_activity(eth_act),
      .eth_speed100(eth_spd), .card_has_prog(card_has), .card_data(card_data), .card_rd_o(card_rd),
      .card_addr_o(card_addr), .nv_prog_valid(nvp), .nv_run(nvr), .perm_retentive(perm),
      .nv_prog_valid_o(nvp_o), .nv_run_o(nvr_o), .nv_keep_o(keep), .prog_empty_o(empty),
      .led_green_o(lg), .led_red_o(lr), .eth_green_o(eg), .eth_orange_o(eo));

   rsc_store_model #(.NIN(NIN), .NOUT(NOUT)) u_part (
      .pclk(pclk), .presetn(presetn), .card_in(card_in), .card_rd(card_rd), .card_addr(card_addr),
      .nv_prog_valid_o(nvp_o), .nv_run_o(nvr_o), .card_has_prog(card_has), .card_data(card_data),
      .nv_prog_valid(nvp), .nv_run(nvr), .exp_power(exp_pwr), .exp_present(exp_present), .exp_green(exp_g),
      .exp_red(exp_r));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic give_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high at a rising edge.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         check(32'(rsp.pready), 32'h1);
         give_verdict;
      end
      rd  = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic pwr;
      @(posedge pclk);
      presetn <= 1'b0;
      cyc(2);
      check({exp_g, exp_r}, 2'b01);
      presetn <= 1'b1;
      cyc(12);
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_empty;
      xfer(0, `RSC_OFF_STAT, 0);
      check(rd & 32'h47, 32'h06);
      @(negedge pclk);
      check({empty, lr, lg, q_o}, 7'b1100000);
      check({exp_g, exp_r}, 2'b10);
      xfer(1, `RSC_OFF_CTRL, 32'h1);
      xfer(0, `RSC_OFF_STAT, 0);
      check(rd[0], 1'b0);
      xfer(0, 8'h40, 0);
      check(err, 1'b1);
   endtask

   task automatic t_run;
      xfer(1, `RSC_OFF_CTRL, 32'h4);
      xfer(0, `RSC_OFF_STAT, 0);
      check(rd[6], 1'b1);
      xfer(1, `RSC_OFF_PROG, 32'h03);
      xfer(1, `RSC_OFF_PROG + 8'h04, 32'h01);
      xfer(1, `RSC_OFF_PROG + 8'h08, 32'h00);
      xfer(1, `RSC_OFF_PROG + 8'h0C, 32'h80);
      xfer(1, `RSC_OFF_CTRL, 32'h8);
      xfer(1, `RSC_OFF_CTRL, 32'h1);
      in_pins <= 8'h03;
      cyc(40);
      xfer(0, `RSC_OFF_INPUT, 0);
      check(rd, 32'h03);
      @(negedge pclk);
      check({lg, q_o}, 5'b10011);
   endtask

   task automatic t_stop;
      xfer(1, `RSC_OFF_CTRL, 32'h2);
      @(negedge pclk);
      check(q_o, 4'h0);
      @(posedge pclk);
      in_pins <= 8'h80;
      cyc(40);
      xfer(0, `RSC_OFF_INPUT, 0);
      check(rd, 32'h03);
      @(negedge pclk);
      check({q_o, lr}, 5'b00001);
      xfer(1, `RSC_OFF_CTRL, 32'h1);
      cyc(40);
      @(negedge pclk);
      check(q_o, 4'h8);
      @(posedge pclk);
      ce      <= 1'b0;
      in_pins <= 8'h03;
      cyc(40);
      @(negedge pclk);
      check({lg, q_o}, 5'b11000);
      @(posedge pclk);
      ce <= 1'b1;
   endtask

   task automatic t_resume;
      pwr;
      xfer(0, `RSC_OFF_STAT, 0);
      check({lg, rd[1:0]}, 3'b101);
      xfer(1, `RSC_OFF_CTRL, 32'h2);
      cyc(20);
      pwr;
      xfer(0, `RSC_OFF_STAT, 0);
      check(rd[1:0], 2'b00);
      xfer(1, `RSC_OFF_CTRL, 32'h4);
      cyc(20);
      pwr;
      xfer(0, `RSC_OFF_STAT, 0);
      check({empty, rd[1]}, 2'b11);
   endtask

   task automatic t_card;
      card_in <= 1'b1;
      pwr;
      for (int i = 0; i < NOUT; i++) begin
         xfer(0, `RSC_OFF_PROG + 8'(4 * i), 0);
         check(rd, 32'(8'h03 << (2 * i)));
      end
      xfer(0, `RSC_OFF_STAT, 0);
      check({nvp_o, rd[1:0]}, 3'b100);
      card_in <= 1'b0;
      nodisp  <= 1'b1;
      cyc(20);
      pwr;
      xfer(0, `RSC_OFF_STAT, 0);
      @(negedge pclk);
      check({rd[5], rd[0], lg, lr}, 4'b1110);
   endtask

   task automatic t_retain;
      xfer(1, `RSC_OFF_RETAIN, 32'h5A);
      xfer(0, `RSC_OFF_RETAIN, 0);
      @(negedge pclk);
      check({keep, rd[30:0]}, {1'b1, 31'h5A});
      xfer(1, `RSC_OFF_RETAIN, 32'h0);
      cyc(1);
      @(negedge pclk);
      check(keep, 1'b0);
      @(posedge pclk);
      perm <= 1'b1;
      cyc(3);
      @(negedge pclk);
      check(keep, 1'b1);
   endtask

   task automatic t_net;
      @(posedge pclk);
      eth_link <= 1'b1;
      eth_spd  <= 1'b1;
      cyc(20);
      xfer(0, `RSC_OFF_STAT, 0);
      check(rd[4:3], 2'b11);
      @(negedge pclk);
      check({eg, eo}, 2'b10);
      @(posedge pclk);
      eth_spd <= 1'b0;
      eth_act <= 1'b1;
      on = 0;
      repeat (24) begin
         @(negedge pclk);
         on += int'(eo);
      end
      check({eg, 1'b0}, 2'b00);
      check(32'(on > 0 && on < 24), 32'h1);
      xfer(0, `RSC_OFF_STAT, 0);
      check(rd[4], 1'b0);
   endtask

   initial begin
      pclk = 1'b0; presetn = 1'b0; ce = 1'b1; nodisp = 1'b0; exp_pwr = 1'b1;
      eth_link = 1'b0; eth_act = 1'b0; eth_spd = 1'b0; card_in = 1'b0; perm = 1'b0;
      req = '0; in_pins = '0; errors = 0; compares = 0;
      cyc(4);
      presetn <= 1'b1;
      cyc(12);
      t_empty;
      t_run;
      t_stop;
      t_resume;
      t_card;
      t_retain;
      t_net;
      give_verdict;
   end
endmodule
